// *** core/tio_pkg.sv ***
package tio_pkg;
   // ==========================================
   // Widths and counter limits
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] GRA_RST = 16'hFFFF;
   localparam logic [3:0] IOC_RST = 4'h0;
   // ==========================================
   // Register offsets, byte addresses
   localparam logic [7:0] OFF_IOC1 = 8'h00;
   localparam logic [7:0] OFF_IOC2 = 8'h04;
   localparam logic [7:0] OFF_GRA1 = 8'h20;
   localparam logic [7:0] OFF_GRA2 = 8'h24;
   localparam logic [7:0] OFF_IEN [3] = '{8'h08, 8'h0C, 8'h10};
   localparam logic [7:0] OFF_STS [3] = '{8'h14, 8'h18, 8'h1C};
   // ==========================================
   // Enable and status layouts
   localparam logic [7:0] IEN_RST = 8'h40;
   localparam logic [7:0] IEN_FIXED = 8'h40;
   localparam logic [7:0] IEN_MASK0 = 8'h1F;
   localparam logic [7:0] IEN_MASK12 = 8'h33;
   localparam logic [5:0] FLG_RST = 6'h00;
   localparam int B_UNF = 5;
   localparam int B_OVF = 4;
   localparam int B_CMPD = 3;
   localparam int B_CMPC = 2;
   localparam int B_CMPB = 1;
   localparam int B_CMPA = 0;
endpackage : tio_pkg

// *** core/tio_chan_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface tio_chan_if;
   logic [3:0] ctrl;
   logic ctrl_wr;
   logic [15:0] cnt;
   logic gra_wr;
   logic [15:0] gra_wdata;
   logic pin_raw;
   logic [15:0] gra;
   logic pin_out;
   logic pin_oe;
   logic match_evt;
   modport ctl (output ctrl, ctrl_wr, cnt, gra_wr, gra_wdata, pin_raw,
                input gra, pin_out, pin_oe, match_evt);
   modport ch (input ctrl, ctrl_wr, cnt, gra_wr, gra_wdata, pin_raw,
               output gra, pin_out, pin_oe, match_evt);
endinterface : tio_chan_if
`default_nettype wire

// *** core/tio_chan_a.sv ***
`timescale 1ns/10ps
`default_nettype none
module tio_chan_a #(
   parameter bit CAP_B2_IGNORED = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   tio_chan_if.ch ch
);
   import tio_pkg::*;
   // ==========================================
   // Pin synchroniser and edge detect
   logic pin_s1_reg;
   logic pin_s2_reg;
   logic pin_s3_reg;
   logic pin_reg;
   logic evt_reg;
   logic [15:0] gra_reg;
   wire out_mode = !ch.ctrl[3];
   wire out_on = out_mode && (ch.ctrl[1:0] != 2'b00);
   // Prohibited code in the channel without a don't-care bit captures nothing
   wire cap_mode = ch.ctrl[3] && (CAP_B2_IGNORED || !ch.ctrl[2]);
   wire rise = pin_s2_reg && !pin_s3_reg;
   wire fall = !pin_s2_reg && pin_s3_reg;
   wire edge_sel = ch.ctrl[1] ? (rise || fall) : (ch.ctrl[0] ? fall : rise);
   wire cap_edge = cap_mode && edge_sel;
   wire hit = out_on && (ch.cnt == gra_reg);
   always_ff @(posedge clk_i) begin
      pin_s1_reg <= ch.pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
   end
   // ==========================================
   // Compare output and capture register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_reg <= 1'b0;
         evt_reg <= 1'b0;
         gra_reg <= GRA_RST;
      end else begin
         evt_reg <= hit || cap_edge;
         if (cap_edge) begin
            gra_reg <= ch.cnt;
         end else if (ch.gra_wr) begin
            gra_reg <= ch.gra_wdata;
         end
         if (ch.ctrl_wr && out_mode) begin
            pin_reg <= ch.ctrl[2];
         end else if (hit) begin
            case (ch.ctrl[1:0])
               2'b01: pin_reg <= 1'b0;
               2'b10: pin_reg <= 1'b1;
               2'b11: pin_reg <= !pin_reg;
               default: pin_reg <= pin_reg;
            endcase
         end
      end
   end
   assign ch.gra = gra_reg;
   assign ch.pin_out = pin_reg;
   assign ch.pin_oe = out_on;
   assign ch.match_evt = evt_reg;
   // ==========================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_pin_init: assert property (ch.ctrl_wr && out_mode |=> pin_reg == $past(ch.ctrl[2]))
      else $error("pin not set to initial level");
   chk_oe_off: assert property (ch.ctrl[1:0] == 2'b00 || ch.ctrl[3] |-> !ch.pin_oe)
      else $error("pin driven while disabled");
   chk_pin_toggle: assert property (hit && !ch.ctrl_wr && ch.ctrl[1:0] == 2'b11
      |=> pin_reg != $past(pin_reg)) else $error("toggle missed");
   chk_cap_load: assert property (cap_edge |=> gra_reg == $past(ch.cnt) && evt_reg)
      else $error("capture did not load counter");
   cov_capture: cover property (cap_edge && ch.ctrl[1]);
endmodule : tio_chan_a
`default_nettype wire

// *** core/tio_top.sv ***
// Function
// - Compare match drives pin low, high, toggle
// - Initial level from bit2; code 00 disables
// - Top bit set: capture on selected edge; channel 1 with bit2 set captures nothing
// - Three enable registers reset to 0x40
// - Enable bit 7 reads 0
// - Enable bit 6 reads 1
// - Bit 5 gates underflow request, channels 1-2
// - Channel 0 bit 5 reserved, reads 0
// - Bit 4 gates overflow request
// - Channel 0 bit 3 gates compare D
// - Channel 0 bit 2 gates compare C
// - Channels 1-2 bits 3,2 reserved zero
// - Bit 1 gates compare B request
// - Bit 0 gates compare A request
// - Request only while flag and enable set
// - Counter wraps set overflow flags, and underflow flags on channels 1-2 only
// - Compare match or capture sets flag
// - Flag clears on read-1 then write-0
`timescale 1ns/10ps
`default_nettype none
module tio_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic [2:0][tio_pkg::CNT_W-1:0] channel_counter_i,
   input wire logic [2:0] count_up_i,
   input wire logic cmp_a0_evt_i,
   input wire logic [2:0] cmp_b_evt_i,
   input wire logic cmp_c_evt_i,
   input wire logic cmp_d_evt_i,
   input wire logic [1:0] pin_a_i,
   output logic [1:0] pin_a_o,
   output logic [1:0] pin_a_oe_o,
   output logic [2:0] overflow_irq_req_o,
   output logic [2:0] underflow_irq_req_o,
   output logic [2:0] cmp_a_irq_req_o,
   output logic [2:0] cmp_b_irq_req_o,
   output logic cmp_c_irq_req_o,
   output logic cmp_d_irq_req_o
);
   import tio_pkg::*;
   // ==========================================
   // Wishbone slave: ack one cycle after the request
   logic ack_reg;
   logic [7:0] rd_next;
   logic [31:0] dat_reg;
   wire req = cyc_i && stb_i;
   wire take = req && ack_reg;
   wire wr_take = take && we_i && sel_i[0];
   wire rd_take = take && !we_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         ack_reg <= req && !ack_reg;
         if (req && !ack_reg) begin
            dat_reg <= {24'h000000, rd_next};
         end
      end
   end
   assign ack_o = ack_reg;
   assign dat_o = dat_reg;
   // ==========================================
   // Pin control registers for channels 1 and 2
   logic [3:0] ioc_reg [1:2];
   logic [1:2] ioc_wr_d_reg;
   logic [7:0] ien_rd [3];
   logic [7:0] sts_rd [3];
   logic [5:0] flags [3];
   logic [5:0] set_vec [3];
   logic [7:0] ien_q [3];
   logic [15:0] gra_q [1:2];
   logic [1:2] chan_evt;
   wire wr_ioc1 = wr_take && (adr_i == OFF_IOC1);
   wire wr_ioc2 = wr_take && (adr_i == OFF_IOC2);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ioc_reg[1] <= IOC_RST;
         ioc_reg[2] <= IOC_RST;
         ioc_wr_d_reg <= 2'b00;
      end else begin
         // Pulse follows the store so the channel sees the new code
         ioc_wr_d_reg <= {wr_ioc1, wr_ioc2};
         if (wr_ioc1) begin
            ioc_reg[1] <= dat_i[3:0];
         end
         if (wr_ioc2) begin
            ioc_reg[2] <= dat_i[3:0];
         end
      end
   end
   // ==========================================
   // Read data selection
   always_comb begin
      rd_next = 8'h00;
      case (adr_i)
         OFF_IOC1: rd_next = {4'h0, ioc_reg[1]};
         OFF_IOC2: rd_next = {4'h0, ioc_reg[2]};
         OFF_IEN[0]: rd_next = ien_rd[0];
         OFF_IEN[1]: rd_next = ien_rd[1];
         OFF_IEN[2]: rd_next = ien_rd[2];
         OFF_STS[0]: rd_next = sts_rd[0];
         OFF_STS[1]: rd_next = sts_rd[1];
         OFF_STS[2]: rd_next = sts_rd[2];
         default: rd_next = 8'h00;
      endcase
   end
   // ==========================================
   // Per-channel flags, enables and requests
   for (genvar c = 0; c < 3; c++) begin : g_ch
      localparam logic [7:0] MASK = (c == 0) ? IEN_MASK0 : IEN_MASK12;
      logic [7:0] ien_reg;
      logic [5:0] flag_reg;
      logic [5:0] seen_reg;
      logic [15:0] prev_reg;
      wire [15:0] cnt = channel_counter_i[c];
      wire ovf = (prev_reg == CNT_MAX) && (cnt == CNT_ZERO);
      wire unf = (c != 0) && (prev_reg == CNT_ZERO) && (cnt == CNT_MAX);
      wire wr_ien = wr_take && (adr_i == OFF_IEN[c]);
      wire wr_sts = wr_take && (adr_i == OFF_STS[c]);
      wire rd_sts = rd_take && (adr_i == OFF_STS[c]);
      // Only a zero written after the flag was read as one clears it
      wire [5:0] clr = {6{wr_sts}} & ~dat_i[5:0] & seen_reg;
      wire [5:0] flag_next = set_vec[c] | (flag_reg & ~clr);
      if (c == 0) begin : g_set0
         assign set_vec[c] = {1'b0, ovf, cmp_d_evt_i, cmp_c_evt_i,
                              cmp_b_evt_i[c], cmp_a0_evt_i};
      end else begin : g_set12
         assign set_vec[c] = {unf, ovf, 2'b00, cmp_b_evt_i[c], chan_evt[c]};
      end
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            ien_reg <= IEN_RST;
            flag_reg <= FLG_RST;
            seen_reg <= FLG_RST;
            prev_reg <= CNT_ZERO;
         end else begin
            prev_reg <= cnt;
            flag_reg <= flag_next;
            // Arm only what the read really returned, not a flag set meanwhile
            if (rd_sts) begin
               seen_reg <= dat_reg[5:0];
            end else if (wr_sts) begin
               seen_reg <= FLG_RST;
            end
            if (wr_ien) begin
               ien_reg <= (dat_i[7:0] & MASK) | IEN_FIXED;
            end
         end
      end
      // Reserved enable bits are forced by the mask on every read
      assign ien_rd[c] = (ien_reg & MASK) | IEN_FIXED;
      assign sts_rd[c] = {(c == 0) ? 1'b1 : count_up_i[c], 1'b1, flag_reg};
      assign flags[c] = flag_reg;
      assign ien_q[c] = ien_rd[c];
      assign overflow_irq_req_o[c] = flag_reg[B_OVF] && ien_rd[c][B_OVF];
      assign underflow_irq_req_o[c] = flag_reg[B_UNF] && ien_rd[c][B_UNF];
      assign cmp_b_irq_req_o[c] = flag_reg[B_CMPB] && ien_rd[c][B_CMPB];
      assign cmp_a_irq_req_o[c] = flag_reg[B_CMPA] && ien_rd[c][B_CMPA];
   end
   assign cmp_d_irq_req_o = flags[0][B_CMPD] && ien_rd[0][B_CMPD];
   assign cmp_c_irq_req_o = flags[0][B_CMPC] && ien_rd[0][B_CMPC];
   // ==========================================
   // Channel A compare and capture, channels 1 and 2
   for (genvar c = 1; c < 3; c++) begin : g_a
      tio_chan_if cif ();
      assign cif.ctrl = ioc_reg[c];
      assign cif.ctrl_wr = ioc_wr_d_reg[c];
      assign cif.cnt = channel_counter_i[c];
      assign cif.gra_wr = wr_take && (adr_i == ((c == 1) ? OFF_GRA1 : OFF_GRA2));
      assign cif.gra_wdata = dat_i[15:0];
      assign cif.pin_raw = pin_a_i[c-1];
      assign pin_a_o[c-1] = cif.pin_out;
      assign pin_a_oe_o[c-1] = cif.pin_oe;
      assign chan_evt[c] = cif.match_evt;
      assign gra_q[c] = cif.gra;
      // Channel 1 has no don't-care bit: its prohibited code captures nothing
      tio_chan_a #(
         .CAP_B2_IGNORED(c == 2)
      ) u_chan (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .ch(cif.ch)
      );
   end
   // ==========================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ien_reset: assert property (disable iff (1'b0) rst_i |=> ien_q[1] == IEN_RST)
      else $error("enable register not at reset value");
   chk_bit7_zero: assert property (!ien_q[0][7] && !ien_q[2][7])
      else $error("enable bit 7 not zero");
   chk_bit6_one: assert property (ien_q[0][6] && ien_q[1][6])
      else $error("enable bit 6 not one");
   chk_res_ch0: assert property (wr_take && adr_i == OFF_IEN[0] |=> !ien_q[0][5])
      else $error("channel 0 bit 5 writable");
   chk_res_ch12: assert property (ien_q[1][3:2] == 2'b00 && ien_q[2][3:2] == 2'b00)
      else $error("reserved enable bits set");
   chk_ien_store: assert property (wr_take && adr_i == OFF_IEN[1]
      |=> ien_q[1] == (($past(dat_i[7:0]) & IEN_MASK12) | IEN_FIXED))
      else $error("enable write not stored");
   chk_ovf_set: assert property ($past(channel_counter_i[0]) == CNT_MAX
      && channel_counter_i[0] == CNT_ZERO |=> flags[0][B_OVF])
      else $error("overflow flag not set");
   chk_unf_irq: assert property (flags[1][B_UNF] && ien_q[1][B_UNF]
      |-> underflow_irq_req_o[1]) else $error("underflow request missing");
   chk_irq_gate: assert property (!ien_q[2][B_OVF] |-> !overflow_irq_req_o[2])
      else $error("request not gated");
   chk_cmp_evt: assert property (chan_evt[1] |=> flags[1][B_CMPA])
      else $error("compare flag not set");
   chk_clear_seq: assert property ($fell(flags[1][B_CMPA])
      |-> $past(wr_take && adr_i == OFF_STS[1] && !dat_i[0]))
      else $error("flag cleared without write");
   chk_gra_write: assert property (wr_take && adr_i == OFF_GRA1 && !ioc_reg[1][3]
      |=> gra_q[1] == $past(dat_i[15:0]))
      else $error("compare value not stored");
   chk_ack_pulse: assert property (ack_o
      |=> !ack_o)
      else $error("ack held past one cycle");
   chk_ack_answer: assert property (cyc_i && stb_i && !ack_o
      |=> ack_o)
      else $error("request not answered");
   chk_rd_upper: assert property (
      dat_o[31:8] == 24'h000000)
      else $error("upper read lanes not zero");
   chk_ioc1_store: assert property (wr_take && adr_i == OFF_IOC1
      |=> ioc_reg[1] == $past(dat_i[3:0]))
      else $error("channel 1 control not stored");
   chk_ioc2_store: assert property (wr_take && adr_i == OFF_IOC2
      |=> ioc_reg[2] == $past(dat_i[3:0]))
      else $error("channel 2 control not stored");
   chk_ien0_store: assert property (wr_take && adr_i == OFF_IEN[0]
      |=> ien_q[0] == (($past(dat_i[7:0]) & IEN_MASK0) | IEN_FIXED))
      else $error("channel 0 enable write not stored");
   chk_ien2_store: assert property (wr_take && adr_i == OFF_IEN[2]
      |=> ien_q[2] == (($past(dat_i[7:0]) & IEN_MASK12) | IEN_FIXED))
      else $error("channel 2 enable write not stored");
   chk_ien_hold: assert property (!(wr_take && adr_i == OFF_IEN[2])
      |=> $stable(ien_q[2]))
      else $error("enable register changed without write");
   chk_ien_reset0: assert property (disable iff (1'b0) rst_i
      |=> ien_q[0] == IEN_RST)
      else $error("channel 0 enable not at reset value");
   chk_ien_reset2: assert property (disable iff (1'b0) rst_i
      |=> ien_q[2] == IEN_RST)
      else $error("channel 2 enable not at reset value");
   chk_bit7_ch1: assert property (
      !ien_q[1][7])
      else $error("channel 1 enable bit 7 not zero");
   chk_bit6_ch2: assert property (
      ien_q[2][6])
      else $error("channel 2 enable bit 6 not one");
   chk_unf_ch0: assert property (
      !underflow_irq_req_o[0] && !flags[0][B_UNF])
      else $error("channel 0 underflow active");
   chk_ovf_gate0: assert property (
      overflow_irq_req_o[0] == (flags[0][B_OVF] && ien_q[0][B_OVF]))
      else $error("channel 0 overflow request wrong");
   chk_cmpd_gate: assert property (
      cmp_d_irq_req_o == (flags[0][B_CMPD] && ien_q[0][B_CMPD]))
      else $error("compare D request wrong");
   chk_cmpc_gate: assert property (
      cmp_c_irq_req_o == (flags[0][B_CMPC] && ien_q[0][B_CMPC]))
      else $error("compare C request wrong");
   chk_cmpb_gate: assert property (
      cmp_b_irq_req_o[1] == (flags[1][B_CMPB] && ien_q[1][B_CMPB]))
      else $error("compare B request wrong");
   chk_cmpa_gate: assert property (
      cmp_a_irq_req_o[2] == (flags[2][B_CMPA] && ien_q[2][B_CMPA]))
      else $error("compare A request wrong");
   chk_unf_set: assert property ($past(channel_counter_i[1]) == CNT_ZERO
      && channel_counter_i[1] == CNT_MAX |=> flags[1][B_UNF])
      else $error("underflow flag not set");
   chk_set_flag0: assert property (set_vec[0][B_CMPB]
      |=> flags[0][B_CMPB])
      else $error("set lost against clear");
   chk_clear_armed: assert property ($fell(flags[0][B_OVF])
      |-> $past(wr_take && adr_i == OFF_STS[0] && !dat_i[B_OVF]))
      else $error("overflow flag cleared without write");
   chk_flag_stay: assert property (flags[2][B_CMPA] && !(wr_take && adr_i == OFF_STS[2])
      |=> flags[2][B_CMPA])
      else $error("flag dropped without status write");
   chk_prohib_off: assert property (ioc_reg[1][3:2] == 2'b11
      |-> !pin_a_oe_o[0])
      else $error("prohibited code drives pin");
   cov_ien_write: cover property (wr_take && adr_i == OFF_IEN[0]);
   cov_ovf_irq: cover property (overflow_irq_req_o[0]);
   cov_flag_clear: cover property ($fell(flags[1][B_CMPA]));
   cov_cmp_d: cover property (cmp_d_irq_req_o);
endmodule : tio_top
`default_nettype wire

// *** bench/tio_pin_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Channel pin wires seen from the board side
module tio_pin_model (
   input wire logic [1:0] ext_level_i,
   input wire logic [1:0] drv_i,
   input wire logic [1:0] drv_oe_i,
   output logic [1:0] wire_o
);
   // A driving channel owns its wire; otherwise the board source sets it
   assign wire_o[0] = drv_oe_i[0] ? drv_i[0] : ext_level_i[0];
   assign wire_o[1] = drv_oe_i[1] ? drv_i[1] : ext_level_i[1];
endmodule : tio_pin_model
`default_nettype wire

// *** bench/timer_io_mode_and_irq_enable_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module timer_io_mode_and_irq_enable_tb_top;
   import tio_pkg::*;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic we_i = 1'h0;
   logic [3:0] sel_i = 4'h0;
   logic cyc_i = 1'h0;
   logic stb_i = 1'h0;
   logic [2:0][15:0] cnt = '0;
   logic a0 = 1'h0;
   logic [2:0] b = 3'h0;
   logic c = 1'h0;
   logic d = 1'h0;
   logic [1:0] ext = 2'h0;
   logic [31:0] q;
   wire logic [31:0] dat_o;
   wire logic ack_o;
   wire logic [1:0] pin_in, pin_o, pin_oe;
   wire logic [2:0] ovf, unf, ra, rb;
   wire logic rc, rd;
   int mismatches = 0;
   int total_checks = 0;
   tio_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
      .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .channel_counter_i(cnt), .count_up_i(3'h7), .cmp_a0_evt_i(a0), .cmp_b_evt_i(b),
      .cmp_c_evt_i(c), .cmp_d_evt_i(d), .pin_a_i(pin_in), .pin_a_o(pin_o),
      .pin_a_oe_o(pin_oe), .overflow_irq_req_o(ovf), .underflow_irq_req_o(unf),
      .cmp_a_irq_req_o(ra), .cmp_b_irq_req_o(rb), .cmp_c_irq_req_o(rc), .cmp_d_irq_req_o(rd));
   tio_pin_model pin_u (.ext_level_i(ext), .drv_i(pin_o), .drv_oe_i(pin_oe), .wire_o(pin_in));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   // ==========================================
   // Compare and bus helpers
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : chk1
   // Entered just after a rising edge; only the watchdog bounds the wait
   task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] dd);
      adr_i <= a;
      we_i <= w;
      dat_i <= {16'h0000, dd};
      sel_i <= 4'hF;
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'h1);
      q = dat_o;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
      @(posedge clk_i);
   endtask : wb
   task automatic clr(input logic [7:0] a);
      wb(a, 1'h0, 16'h0000);
      wb(a, 1'h1, 16'h0000);
   endtask : clr
   // ==========================================
   // Scenarios
   task automatic t_reset;
      for (int i = 0; i < 3; i++) begin
         wb(OFF_IEN[i], 1'h0, 16'h0000);
         chk8(q[7:0], 8'h40);
      end
      wb(OFF_IOC1, 1'h0, 16'h0000);
      chk8(q[7:0], 8'h00);
      wb(OFF_IOC2, 1'h0, 16'h0000);
      chk8(q[7:0], 8'h00);
      wb(8'h30, 1'h0, 16'h0000);
      chk8(q[7:0], 8'h00);
      chk8({6'h0, pin_oe}, 8'h00);
   endtask : t_reset
   task automatic t_ien_bits;
      for (int i = 0; i < 3; i++) begin
         wb(OFF_IEN[i], 1'h1, 16'h007F);
         wb(OFF_IEN[i], 1'h0, 16'h0000);
         chk8(q[7:0], (i == 0) ? 8'h5F : 8'h73);
         wb(OFF_IEN[i], 1'h1, 16'h0040);
         wb(OFF_IEN[i], 1'h0, 16'h0000);
         chk8(q[7:0], 8'h40);
      end
   endtask : t_ien_bits
   task automatic t_ch0_gate;
      cnt[0] <= 16'hFFFF;
      a0 <= 1'h1;
      b[0] <= 1'h1;
      c <= 1'h1;
      d <= 1'h1;
      @(posedge clk_i);
      {a0, b[0], c, d} <= 4'h0;
      cnt[0] <= 16'h0000;
      repeat (3) @(posedge clk_i);
      chk8({3'h0, ovf[0], rd, rc, rb[0], ra[0]}, 8'h00);
      wb(OFF_IEN[0], 1'h1, 16'h005F);
      chk8({3'h0, ovf[0], rd, rc, rb[0], ra[0]}, 8'h1F);
      wb(OFF_IEN[0], 1'h1, 16'h0045);
      chk8({3'h0, ovf[0], rd, rc, rb[0], ra[0]}, 8'h05);
      clr(OFF_STS[0]);
      chk8({3'h0, ovf[0], rd, rc, rb[0], ra[0]}, 8'h00);
   endtask : t_ch0_gate
   task automatic t_wrap;
      wb(OFF_IEN[1], 1'h1, 16'h0070);
      // Leave zero first so the climb to all ones is no underflow
      cnt[1] <= 16'h0001;
      @(posedge clk_i);
      cnt[1] <= 16'hFFFF;
      @(posedge clk_i);
      cnt[1] <= 16'h0000;
      repeat (3) @(posedge clk_i);
      chk8({5'h0, unf[0], unf[1], ovf[1]}, 8'h01);
      cnt[1] <= 16'hFFFF;
      repeat (3) @(posedge clk_i);
      chk8({5'h0, unf[0], unf[1], ovf[1]}, 8'h03);
      clr(OFF_STS[1]);
      chk8({5'h0, unf[0], unf[1], ovf[1]}, 8'h00);
      wb(OFF_IEN[1], 1'h1, 16'h0040);
   endtask : t_wrap
   task automatic t_compare;
      logic [3:0] m;
      logic aft;
      wb(OFF_GRA1, 1'h1, 16'h0010);
      for (int k = 1; k < 8; k++) begin
         m = 4'(k);
         aft = (m[1:0] == 2'h1) ? 1'h0 : (m[1:0] == 2'h2) ? 1'h1 : ~m[2];
         if (k != 4) begin
            wb(OFF_IOC1, 1'h1, 16'(k));
            @(posedge clk_i);
            chk8({6'h0, pin_oe[0], pin_o[0]}, {6'h0, 1'h1, m[2]});
            cnt[1] <= 16'h0010;
            @(posedge clk_i);
            cnt[1] <= 16'h0005;
            repeat (3) @(posedge clk_i);
            chk8({6'h0, pin_oe[0], pin_o[0]}, {6'h0, 1'h1, aft});
         end
      end
      wb(OFF_IOC1, 1'h1, 16'h0004);
      @(posedge clk_i);
      chk1(pin_oe[0], 1'h0);
   endtask : t_compare
   task automatic t_capture;
      // Code E sets the ignored bit two; software never uses the prohibited channel 1 code
      logic [3:0] cc [4] = '{4'h8, 4'h9, 4'hA, 4'hE};
      wb(OFF_IEN[2], 1'h1, 16'h0041);
      for (int j = 0; j < 4; j++) begin
         wb(OFF_IOC2, 1'h1, {12'h000, cc[j]});
         clr(OFF_STS[2]);
         ext[1] <= 1'h1;
         repeat (6) @(posedge clk_i);
         chk1(ra[2], cc[j] != 4'h9);
         chk8({6'h0, pin_oe[1], pin_o[1]}, 8'h00);
         clr(OFF_STS[2]);
         ext[1] <= 1'h0;
         repeat (6) @(posedge clk_i);
         chk1(ra[2], cc[j] != 4'h8);
      end
   endtask : t_capture
   // ==========================================
   // Sequence, watchdog and verdict
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      t_reset;
      t_ien_bits;
      t_ch0_gate;
      t_wrap;
      t_compare;
      t_capture;
      results;
   end
   // Whole run needs well under two thousand cycles
   initial begin
      #2000000;
      mismatches++;
      results;
   end
endmodule : timer_io_mode_and_irq_enable_tb_top
`default_nettype wire
